// *** src/cic_pkg.sv ***
// package of constants and types for the core interrupt controller
package cic_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] OFS_IRQ_CONTROL = 4'h0;
    localparam logic [3:0] OFS_PERIPH_FLAG_1 = 4'h1;
    localparam logic [3:0] OFS_PERIPH_FLAG_2 = 4'h2;
    localparam logic [3:0] OFS_PERIPH_ENABLE_1 = 4'h3;
    localparam logic [3:0] OFS_PERIPH_ENABLE_2 = 4'h4;
    localparam logic [3:0] OFS_PIN_CHANGE_FLAG = 4'h5;
    localparam logic [3:0] OFS_OPTION = 4'h6;
    localparam logic [3:0] OFS_SHADOW_STATUS = 4'h7;
    localparam logic [3:0] OFS_SHADOW_WREG = 4'h8;
    // control register bit positions; BIT_EDGE is the edge-select bit of the option register
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PGIE = 6;
    localparam int BIT_TMR_IE = 5;
    localparam int BIT_EXT_IE = 4;
    localparam int BIT_PC_IE = 3;
    localparam int BIT_TMR_IF = 2;
    localparam int BIT_EXT_IF = 1;
    localparam int BIT_PC_IF = 0;
    localparam int BIT_EDGE = 6;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'h40;
    localparam logic [14:0] RST_PC = 15'h0000;
    // vector and status mask (timeout and power-down bits are not saved)
    localparam logic [14:0] IRQ_VECTOR = 15'h0004;
    localparam logic [7:0] STATUS_SAVE_MASK = 8'he7;
    // entry sequence length in instruction cycles
    localparam logic [1:0] ENTRY_CYCLES = 2'h2;
    // entry sequence states
    typedef enum logic [2:0]
    {
        CIC_IDLE = 3'b001,
        CIC_FLUSH = 3'b010,
        CIC_VECTOR = 3'b100
    } cic_state_t;
endpackage

// *** src/cic_core.sv ***
// core interrupt controller: flags, enables, entry, return, sleep wake
`timescale 1ns/10ps
`default_nettype none
// How it works
// - any reset clears every enable
// - redirect needs global and own enables, plus group enable for peripherals
// - flags set regardless of enables
// - flags in control and two peripheral registers
// - entry flushes, clears global, pushes, saves, vectors
// - one vector, firmware polls flags
// - global clear means flag only
// - pending interrupt taken when global set again
// - return pops, restores shadows, sets global
// - synchronous latency three or four cycles
// - asynchronous latency three to five cycles
// - latency independent of instruction length
// - pin flag sampled each Q1 phase
// - only clockless sources wake from sleep
// - wake vectors if global set, else resumes
// - instruction after sleep runs before handler
// - pin edge-triggered, select set chooses rising edge, clear falling
// - valid pin edge sets flag, may redirect
// - context saved to shadows and restored
// - pin-change summary flag read-only derived
module cic_core
    import cic_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic q1_phase,
    input wire logic tmr_overflow,
    input wire logic [7:0] periph_event_1,
    input wire logic [7:0] periph_event_2,
    input wire logic [5:0] pin_change_event,
    input wire logic ext_pin,
    input wire logic in_sleep,
    input wire logic [7:0] wake_capable_1,
    input wire logic after_sleep_done,
    input wire logic return_from_handler,
    input wire logic [14:0] cur_pc,
    input wire logic [7:0] cur_wreg,
    input wire logic [7:0] cur_status,
    input wire logic [7:0] cur_bsr,
    input wire logic [15:0] cur_fsr0,
    input wire logic [15:0] cur_fsr1,
    input wire logic [6:0] cur_pclath,
    output logic flush_prefetch,
    output logic push_pc,
    output logic [14:0] push_value,
    output logic load_pc,
    output logic [14:0] load_value,
    output logic pop_pc,
    output logic restore_ctx,
    output logic [7:0] shadow_wreg,
    output logic [7:0] shadow_status,
    output logic [7:0] shadow_bsr,
    output logic [15:0] shadow_fsr0,
    output logic [15:0] shadow_fsr1,
    output logic [6:0] shadow_pclath,
    output logic wake_up,
    output logic irq_request
);
    typedef struct packed
    {
        cic_state_t state;
        logic [1:0] cnt;
        logic [7:0] ctrl;
        logic [7:0] pflag1;
        logic [7:0] pflag2;
        logic [7:0] pen1;
        logic [7:0] pen2;
        logic [5:0] pcflag;
        logic [7:0] option;
        logic [2:0] pin_sync;
        logic pin_level;
        logic ext_latch;
        logic wake_pend;
        logic [7:0] rdata;
        logic flush;
        logic push;
        logic [14:0] push_value;
        logic load;
        logic pop;
        logic restore;
        logic [7:0] sh_w;
        logic [7:0] sh_st;
        logic [7:0] sh_bsr;
        logic [15:0] sh_f0;
        logic [15:0] sh_f1;
        logic [6:0] sh_pcl;
        logic wake;
        logic irq;
        logic [14:0] vec;
    } cic_regs_t;

    cic_regs_t r;
    cic_regs_t next_r;

    logic pc_summary;
    logic pend_any;
    logic pend_wake;
    logic edge_seen;
    logic irq_take;

    // summary flag follows the individual pin-change flags only
    assign pc_summary = |r.pcflag;

    // enabled pending term; group terms also need group enable
    assign pend_any = (r.ctrl[BIT_TMR_IE] & r.ctrl[BIT_TMR_IF])
        | (r.ctrl[BIT_EXT_IE] & r.ctrl[BIT_EXT_IF])
        | (r.ctrl[BIT_PC_IE] & pc_summary)
        | (r.ctrl[BIT_PGIE] & |((r.pflag1 & r.pen1) | (r.pflag2 & r.pen2)));

    // only clockless peripheral sources can wake the core
    assign pend_wake = (r.ctrl[BIT_EXT_IE] & r.ctrl[BIT_EXT_IF])
        | (r.ctrl[BIT_PC_IE] & pc_summary)
        | (r.ctrl[BIT_PGIE] & |(r.pflag1 & r.pen1 & wake_capable_1));

    // synchronised pin level: change counts once stages two and three agree
    assign edge_seen = (r.pin_sync[2] == r.pin_sync[1]) && (r.pin_sync[1] != r.pin_level)
        && (r.pin_sync[1] == r.option[BIT_EDGE]);

    // recognition on Q1 only, keeping latency fixed by phase; a return still
    // in flight blocks it, so the pc pushed is the one the core has popped
    assign irq_take = q1_phase && r.ctrl[BIT_GLOBAL_EN] && pend_any && !in_sleep
        && !r.wake_pend && !r.pop && r.state == CIC_IDLE;

    always_comb
    begin
        next_r = r;
        next_r.pin_sync = {r.pin_sync[1:0], ext_pin};
        next_r.flush = 1'b0;
        next_r.push = 1'b0;
        next_r.load = 1'b0;
        next_r.pop = 1'b0;
        next_r.restore = 1'b0;
        next_r.wake = 1'b0;
        next_r.rdata = RST_BYTE;
        if (r.pin_sync[2] == r.pin_sync[1])
        begin
            next_r.pin_level = r.pin_sync[1];
        end

        // software writes first; hardware events below win over clears
        if (wr_en)
        begin
            if (addr == OFS_IRQ_CONTROL)
            begin
                next_r.ctrl = {wdata[7:1], 1'b0};
            end
            else if (addr == OFS_PERIPH_FLAG_1)
            begin
                next_r.pflag1 = wdata;
            end
            else if (addr == OFS_PERIPH_FLAG_2)
            begin
                next_r.pflag2 = wdata;
            end
            else if (addr == OFS_PERIPH_ENABLE_1)
            begin
                next_r.pen1 = wdata;
            end
            else if (addr == OFS_PERIPH_ENABLE_2)
            begin
                next_r.pen2 = wdata;
            end
            else if (addr == OFS_PIN_CHANGE_FLAG)
            begin
                next_r.pcflag = wdata[5:0];
            end
            else if (addr == OFS_OPTION)
            begin
                next_r.option = wdata;
            end
            else if (addr == OFS_SHADOW_STATUS)
            begin
                next_r.sh_st = wdata & STATUS_SAVE_MASK;
            end
            else if (addr == OFS_SHADOW_WREG)
            begin
                next_r.sh_w = wdata;
            end
        end

        // event capture ignores every enable
        next_r.ctrl[BIT_TMR_IF] = next_r.ctrl[BIT_TMR_IF] | tmr_overflow;
        next_r.pflag1 = next_r.pflag1 | periph_event_1;
        next_r.pflag2 = next_r.pflag2 | periph_event_2;
        next_r.pcflag = next_r.pcflag | pin_change_event;
        // edge held until the next Q1 so the flag is visible at recognition
        if (edge_seen)
        begin
            next_r.ext_latch = 1'b1;
        end
        if (q1_phase && (r.ext_latch || edge_seen))
        begin
            next_r.ctrl[BIT_EXT_IF] = 1'b1;
            next_r.ext_latch = 1'b0;
        end

        // sleep wake: resume first, vector only after the next instruction;
        // the clear comes first so a wake in the same cycle wins
        if (r.wake_pend && after_sleep_done)
        begin
            next_r.wake_pend = 1'b0;
        end
        if (in_sleep && pend_wake)
        begin
            next_r.wake = 1'b1;
            next_r.wake_pend = r.ctrl[BIT_GLOBAL_EN];
        end

        // entry sequence
        case (r.state)
            CIC_IDLE:
            begin
                if (irq_take)
                begin
                    next_r.state = CIC_FLUSH;
                    next_r.cnt = ENTRY_CYCLES;
                    next_r.flush = 1'b1;
                    next_r.ctrl[BIT_GLOBAL_EN] = 1'b0;
                    next_r.push = 1'b1;
                    next_r.push_value = cur_pc;
                    next_r.sh_w = cur_wreg;
                    next_r.sh_st = cur_status & STATUS_SAVE_MASK;
                    next_r.sh_bsr = cur_bsr;
                    next_r.sh_f0 = cur_fsr0;
                    next_r.sh_f1 = cur_fsr1;
                    next_r.sh_pcl = cur_pclath;
                end
                else if (return_from_handler)
                begin
                    next_r.pop = 1'b1;
                    next_r.restore = 1'b1;
                    next_r.ctrl[BIT_GLOBAL_EN] = 1'b1;
                end
            end
            CIC_FLUSH:
            begin
                if (q1_phase)
                begin
                    next_r.cnt = r.cnt - 2'h1;
                    if (r.cnt == 2'h1)
                    begin
                        next_r.state = CIC_VECTOR;
                    end
                end
            end
            CIC_VECTOR:
            begin
                next_r.load = 1'b1;
                next_r.state = CIC_IDLE;
            end
            default:
            begin
                next_r.state = CIC_IDLE;
            end
        endcase

        next_r.irq = r.ctrl[BIT_GLOBAL_EN] & pend_any;
        next_r.vec = IRQ_VECTOR;

        // read data one cycle after the strobe
        if (rd_en)
        begin
            if (addr == OFS_IRQ_CONTROL)
            begin
                next_r.rdata = {r.ctrl[7:1], pc_summary};
            end
            else if (addr == OFS_PERIPH_FLAG_1)
            begin
                next_r.rdata = r.pflag1;
            end
            else if (addr == OFS_PERIPH_FLAG_2)
            begin
                next_r.rdata = r.pflag2;
            end
            else if (addr == OFS_PERIPH_ENABLE_1)
            begin
                next_r.rdata = r.pen1;
            end
            else if (addr == OFS_PERIPH_ENABLE_2)
            begin
                next_r.rdata = r.pen2;
            end
            else if (addr == OFS_PIN_CHANGE_FLAG)
            begin
                next_r.rdata = {2'h0, r.pcflag};
            end
            else if (addr == OFS_OPTION)
            begin
                next_r.rdata = r.option;
            end
            else if (addr == OFS_SHADOW_STATUS)
            begin
                next_r.rdata = r.sh_st;
            end
            else if (addr == OFS_SHADOW_WREG)
            begin
                next_r.rdata = r.sh_w;
            end
        end
    end

    // reset clears every enable so nothing redirects until software acts
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            r <= '0;
            r.state <= CIC_IDLE;
            r.option <= RST_OPTION;
            r.push_value <= RST_PC;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign flush_prefetch = r.flush;
    assign push_pc = r.push;
    assign push_value = r.push_value;
    assign load_pc = r.load;
    assign load_value = r.vec;
    assign pop_pc = r.pop;
    assign restore_ctx = r.restore;
    assign shadow_wreg = r.sh_w;
    assign shadow_status = r.sh_st;
    assign shadow_bsr = r.sh_bsr;
    assign shadow_fsr0 = r.sh_f0;
    assign shadow_fsr1 = r.sh_f1;
    assign shadow_pclath = r.sh_pcl;
    assign wake_up = r.wake;
    assign irq_request = r.irq;

    // entry always flushes and pushes together, then vectors
    sequence s_entry;
        push_pc && flush_prefetch;
    endsequence
    a_entry_order: assert property (@(posedge clk) disable iff (!resetn)
        s_entry |-> !r.ctrl[BIT_GLOBAL_EN] ##[1:300] load_pc) else $error("entry without vector load");
    a_global_off_quiet: assert property (@(posedge clk) disable iff (!resetn)
        (r.state == CIC_IDLE && !r.ctrl[BIT_GLOBAL_EN]) |=> !push_pc) else $error("entry with global off");
    a_return_sets: assert property (@(posedge clk) disable iff (!resetn)
        pop_pc |-> restore_ctx && r.ctrl[BIT_GLOBAL_EN]) else $error("return incomplete");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
        tmr_overflow |=> r.ctrl[BIT_TMR_IF]) else $error("timer flag missed");
    a_reset_off: assert property (@(posedge clk)
        !resetn |=> !r.ctrl[BIT_GLOBAL_EN] && !irq_request) else $error("enable survives reset");
    a_summary_ro: assert property (@(posedge clk) disable iff (!resetn)
        (r.pcflag == 6'h00) |-> !pc_summary) else $error("summary stuck");
    a_request_or: assert property (@(posedge clk) disable iff (!resetn)
        irq_request |-> $past(r.ctrl[BIT_GLOBAL_EN])) else $error("request without global");
    a_shadow_mask: assert property (@(posedge clk) disable iff (!resetn)
        push_pc |-> (shadow_status & ~STATUS_SAVE_MASK) == 8'h00) else $error("status mask");
endmodule
`default_nettype wire

// *** testbench/cic_core_model.sv ***
// behavioural core sequencer and handler firmware facing the controller
`timescale 1ns/10ps
`default_nettype none
module cic_core_model
    import cic_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic do_ret,
    input wire logic do_next,
    input wire logic [7:0] ctx,
    input wire logic push_pc,
    input wire logic [14:0] push_value,
    input wire logic load_pc,
    input wire logic [14:0] load_value,
    input wire logic pop_pc,
    output logic q1_phase,
    output logic return_from_handler,
    output logic after_sleep_done,
    output logic [14:0] cur_pc,
    output logic [7:0] cur_wreg,
    output logic [7:0] cur_status,
    output logic [7:0] cur_bsr,
    output logic [15:0] cur_fsr0,
    output logic [15:0] cur_fsr1,
    output logic [6:0] cur_pclath
);
    logic [1:0] qcnt;
    logic [14:0] stack[$];
    // context follows ctx so the bench knows what the shadows must hold
    assign cur_wreg = ctx;
    assign cur_status = ctx ^ 8'h18;
    assign cur_bsr = ~ctx;
    assign cur_fsr0 = {ctx, ~ctx};
    assign cur_fsr1 = {~ctx, ctx};
    assign cur_pclath = ctx[6:0];
    // known levels before the first edge, so nothing reaches the design as unknown
    initial
    begin
        qcnt = 2'h0;
        q1_phase = 1'b0;
        return_from_handler = 1'b0;
        after_sleep_done = 1'b0;
        cur_pc = 15'h0000;
    end
    // four clocks to an instruction; the pc steps once per instruction
    always @(posedge clk)
    begin
        return_from_handler <= do_ret;
        after_sleep_done <= do_next;
        if (!resetn)
        begin
            qcnt <= 2'h0;
            q1_phase <= 1'b0;
            cur_pc <= 15'h0000;
            stack.delete();
        end
        else
        begin
            qcnt <= qcnt + 2'h1;
            q1_phase <= (qcnt == 2'h3);
            if (push_pc)
                stack.push_back(push_value);
            if (load_pc)
                cur_pc <= load_value;
            else if (pop_pc && stack.size() > 0)
                cur_pc <= stack.pop_back();
            else if (qcnt == 2'h3)
                cur_pc <= cur_pc + 15'h0001;
        end
    end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the core interrupt controller
`timescale 1ns/10ps
`default_nettype none
module testbench
    import cic_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic tmr_overflow = 1'b0;
    logic [7:0] periph_event_1 = 8'h00;
    logic [7:0] periph_event_2 = 8'h00;
    logic [5:0] pin_change_event = 6'h00;
    logic ext_pin = 1'b0;
    logic in_sleep = 1'b0;
    logic [7:0] wake_capable_1 = 8'h01;
    logic do_ret = 1'b0;
    logic do_next = 1'b0;
    logic [7:0] ctx = 8'h5a;
    logic q1_phase, after_sleep_done, return_from_handler, flush_prefetch, push_pc, load_pc, pop_pc;
    logic restore_ctx, wake_up, irq_request;
    logic [14:0] cur_pc, push_value, load_value;
    logic [7:0] rdata, cur_wreg, cur_status, cur_bsr, shadow_wreg, shadow_status, shadow_bsr;
    logic [15:0] cur_fsr0, cur_fsr1, shadow_fsr0, shadow_fsr1;
    logic [6:0] cur_pclath, shadow_pclath;
    int m[9];
    int seed = 21;
    int bad_count = 0;
    int n_tests = 0;
    int i, k, lat_cyc;
    time t_ev;

    cic_core DUT (.*);
    cic_core_model far_side (.*);

    // 25 MHz clock, four clocks to an instruction
    always #20 clk = ~clk;

    // hang guard: a stuck run still reaches the verdict
    initial
    begin
        #4000000;
        bad_count++;
        give_verdict();
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input int exp);
        n_tests++;
        if (got !== exp[15:0])
        begin
            bad_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp[15:0]);
        end
    endtask

    task automatic mreset();
        foreach (m[j]) m[j] = 0;
        m[6] = 'h40;
    endtask

    // summary bit of control is derived from the pin-change flags
    function automatic int expv(input int a);
        if (a == 0)
            return (m[0] & 'hfe) | int'(m[5] != 0);
        return (a < 9) ? m[a] : 0;
    endfunction

    task automatic wr(input int a, input int d);
        @(posedge clk);
        addr <= a[3:0];
        wdata <= d[7:0];
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        if (a == 0)
            m[0] = d & 'hfe;
        else if (a < 9)
            m[a] = d;
    endtask

    task automatic rd(input int a);
        @(posedge clk);
        addr <= a[3:0];
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, expv(a));
    endtask

    // one-cycle event pulse on source a; the model flag is set at once
    task automatic ev(input int a, input int v);
        v = v & ((a == 5) ? 'h3f : 'hff);
        @(posedge clk);
        tmr_overflow <= (a == 0);
        periph_event_1 <= (a == 1) ? v[7:0] : 8'h00;
        periph_event_2 <= (a == 2) ? v[7:0] : 8'h00;
        pin_change_event <= (a == 5) ? v[5:0] : 6'h00;
        @(posedge clk);
        tmr_overflow <= 1'b0;
        periph_event_1 <= 8'h00;
        periph_event_2 <= 8'h00;
        pin_change_event <= 6'h00;
        t_ev = $time;
        m[a] |= v;
    endtask

    // s: 0 push, 1 wake, 2 load, 3 pop; pulses are looked at in their cycle
    task automatic waitp(input int s, input int lim, input int want);
        logic hit;
        hit = 1'b0;
        for (int j = 0; j < lim && hit !== 1'b1; j++)
        begin
            @(posedge clk);
            #1;
            hit = (s == 0) ? push_pc : (s == 1) ? wake_up : (s == 2) ? load_pc : pop_pc;
        end
        chk(hit, want);
        if (want == 1 && hit !== 1'b1)
            give_verdict();
    endtask

    task automatic entered();
        waitp(0, 24, 1);
        chk(flush_prefetch, 1);
        chk(shadow_wreg, ctx);
        chk(shadow_status, (ctx ^ 'h18) & STATUS_SAVE_MASK);
        chk(shadow_pclath, ctx[6:0]);
        chk(shadow_bsr, 8'(~ctx));
        chk(shadow_fsr0, {ctx, ~ctx});
        chk(shadow_fsr1, {~ctx, ctx});
        chk(push_value, cur_pc);
        m[0] &= 'h7f;
        m[7] = (ctx ^ 'h18) & STATUS_SAVE_MASK;
        m[8] = ctx;
        waitp(2, 12, 1);
        chk(load_value, IRQ_VECTOR);
        lat_cyc = int'(($time - t_ev) / 40);
        ctx <= 8'($random(seed));
    endtask

    task automatic ret();
        @(posedge clk);
        do_ret <= 1'b1;
        @(posedge clk);
        do_ret <= 1'b0;
        waitp(3, 8, 1);
        chk(restore_ctx, 1);
        chk(shadow_wreg, m[8]);
        m[0] |= 'h80;
    endtask

    // main sequence
    initial
    begin
        mreset();
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 16; i++) rd(i);
        ev(0, 4);
        ev(1, $random(seed));
        ev(2, $random(seed));
        ev(5, 'h21);
        for (i = 0; i < 6; i++) rd(i);
        chk(irq_request, 0);
        wr(0, 0);
        rd(0);
        wr(5, 0);
        rd(0);
        wr(1, 0);
        wr(2, 0);
        $display("test done: flags");
        wr(3, 'h02);
        wr(0, 'h80);
        ev(1, 'h02);
        waitp(0, 24, 0);
        chk(irq_request, 0);
        wr(0, 'he0);
        entered();
        rd(0);
        rd(7);
        ev(0, 4);
        waitp(0, 24, 0);
        wr(1, 0);
        ret();
        entered();
        wr(0, 'h60);
        ret();
        rd(0);
        $display("test done: entry and return");
        // vary the event's place within the instruction cycle
        for (k = 0; k < 4; k++)
        begin
            repeat (k) @(posedge clk);
            ev(0, 4);
            entered();
            chk(lat_cyc >= 8 && lat_cyc <= 16, 1);
            wr(0, 'h60);
            ret();
        end
        $display("test done: latency");
        wr(0, 'h10);
        for (k = 0; k < 4; k++)
        begin
            if (k == 2)
                wr(6, 0);
            @(posedge clk);
            ext_pin <= ~ext_pin;
            repeat (8) @(posedge clk);
            if (k == 0 || k == 3)
                m[0] |= 2;
            rd(0);
            wr(0, 'h10);
        end
        @(posedge clk);
        ext_pin <= 1'b1;
        repeat (8) @(posedge clk);
        wr(0, 'h90);
        @(posedge clk);
        ext_pin <= 1'b0;
        t_ev = $time;
        m[0] |= 2;
        entered();
        chk(lat_cyc <= 20, 1);
        wr(0, 'h10);
        ret();
        wr(0, 0);
        $display("test done: pin edges");
        wr(3, 'h03);
        wr(0, 'h40);
        in_sleep <= 1'b1;
        ev(1, 'h02);
        waitp(1, 12, 0);
        ev(1, 'h01);
        waitp(1, 12, 1);
        waitp(0, 20, 0);
        in_sleep <= 1'b0;
        wr(1, 0);
        wr(0, 'hc0);
        in_sleep <= 1'b1;
        ev(1, 'h01);
        waitp(1, 12, 1);
        waitp(0, 20, 0);
        chk(irq_request, 1);
        @(posedge clk);
        do_next <= 1'b1;
        in_sleep <= 1'b0;
        @(posedge clk);
        do_next <= 1'b0;
        entered();
        wr(1, 0);
        ret();
        $display("test done: sleep wake");
        wr(0, 'hf8);
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        mreset();
        for (i = 0; i < 9; i++) rd(i);
        ev(0, 4);
        waitp(0, 24, 0);
        $display("test done: second reset");
        give_verdict();
    end
endmodule
`default_nettype wire
